// File: rtl/cca_defs.vh
// Constants for the dual capture/compare array: register map,
// field positions, mode codes and reset values.
// Assumes byte addresses on a 12-bit AXI4-Lite address bus.
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// Register map (byte addresses)
`define A_TMR_REGION 6'h00
`define A_CHV_REGION 5'h02
`define A_CHM_REGION 5'h04
`define A_STATUS 12'h300
`define A_MASK 12'h304

// Word offsets inside one timer slot of 16 bytes
`define TOFF_CTL 2'h0
`define TOFF_VAL 2'h1
`define TOFF_REL 2'h2
`define TOFF_NONE 2'h3

// Timer control fields
`define TC_SEL 2:0
`define TC_SRC 4:3
`define TC_RUN 5

// Timer count sources
`define SRC_PRE 2'h0
`define SRC_AUX 2'h1
`define SRC_EXT 2'h2

// Channel mode fields
`define CM_MODE 2:0
`define CM_EDGE 4:3
`define CM_TSEL 5

// Channel modes
`define MD_OFF 3'h0
`define MD_CAP 3'h1
`define MD_C0 3'h2
`define MD_C1 3'h3
`define MD_C2 3'h4
`define MD_C3 3'h5
`define MD_DBL 3'h6

// Prescaler: divisor for code 000, doubled per code step
`define PRE_BASE 10'h008
`define PRE_ONE 10'h001

// Reset values and the timer top count
`define RST_CTL 6'h00
`define RST_W16 16'h0000
`define RST_W32 32'h0000_0000
`define TMR_TOP 16'hFFFF

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// File: rtl/dual_capture_compare_array.v
// Two 16-channel capture/compare arrays with four reloadable timers,
// registers on an AXI4-Lite slave, one level interrupt output.
// Assumes MCLK is the only clock; AUX_OVF is a one-cycle pulse on MCLK,
// while CC_IN and EXT_COUNT are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "cca_defs.vh"

// What this block does
// - Two arrays of 16 channels, each channel picks either timer of its pair.
// - Four 16-bit timers with reload registers, paired per array.
// - Timer counts on prescaled clock or auxiliary unit overflow pulse.
// - First timer of each pair can also count an external pin.
// - Three-bit select divides clock by 8, doubling per code up to 1024.
// - Each channel owns one pin; channels 24 to 27 never drive it.
// - Capture copies the assigned timer value into the channel register.
// - Every capture raises that channel's interrupt request.
// - Capture edge selectable: rising, falling or both.
// - Compare channels match stored value against assigned timer on each count of that timer.
// - Mode 0 raises request on every match, pin untouched.
// - Mode 1 toggles the pin on every match.
// - Mode 2 raises request only on first match per period.
// - Mode 3 sets pin on first match, timer overflow clears it.
// - Double mode: channel and its partner toggle one shared pin.
// - Reload zero gives a full 16-bit period at the chosen rate.
module dual_capture_compare_array #(
	parameter PRE_W = 10
) (
	// Clock and reset
	input wire MCLK,
	input wire SYS_RST,
	// AXI4-Lite register slave
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// Channel pins
	input wire [31:0] CC_IN,
	output wire [31:0] CC_OUT,
	output wire [31:0] CC_OE,
	// Timer count inputs
	input wire [1:0] EXT_COUNT,
	input wire AUX_OVF,
	// Interrupt
	output wire IRQ
);

	function [15:0] mrg16;
		input [15:0] o;
		input [15:0] d;
		input [1:0] s;
		begin
			mrg16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
		end
	endfunction

	// Bus slave
	reg aw_q;
	reg w_q;
	reg b_q;
	reg r_q;
	reg [11:0] awa_q;
	reg [31:0] wd_q;
	reg [31:0] rdata_q;
	reg [3:0] ws_q;
	reg [1:0] bresp_q;
	reg [1:0] rresp_q;
	reg [31:0] rd;
	reg rok;
	reg wok;
	wire wdo = aw_q && w_q && !b_q;
	// Reads answer one cycle after the address, with no wait states
	wire rdo = S_AXI_ARVALID && !r_q;
	assign S_AXI_AWREADY = !aw_q && !b_q;
	assign S_AXI_WREADY = !w_q && !b_q;
	assign S_AXI_ARREADY = !r_q;
	assign S_AXI_BVALID = b_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_RVALID = r_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	wire wt = wdo && awa_q[11:6] == `A_TMR_REGION;
	wire wcv = wdo && awa_q[11:7] == `A_CHV_REGION;
	wire wcm = wdo && awa_q[11:7] == `A_CHM_REGION;
	wire wmk = wdo && awa_q == `A_MASK;

	// Shared timebase state
	reg [PRE_W-1:0] pre_q;
	reg [1:0] e1_q;
	reg [1:0] e2_q;
	reg [1:0] e3_q;
	reg [31:0] p1_q;
	reg [31:0] p2_q;
	reg [31:0] p3_q;
	reg [31:0] st_q;
	reg [31:0] mk_q;
	// Edges come from stages two and three, never from the first
	wire [1:0] e_rise = e2_q & ~e3_q;
	wire [31:0] p_rise = p2_q & ~p3_q;
	wire [31:0] p_fall = ~p2_q & p3_q;

	wire [63:0] tval_f, trel_f;
	wire [23:0] tctl_f;
	wire [3:0] tupd, tovf;
	wire [511:0] cv_f;
	wire [191:0] cm_f;
	wire [31:0] evt;
	wire [31:0] tog;
	wire [31:0] dbl;
	wire [31:0] oem;
	wire [31:0] set3;
	wire [31:0] clr3;

	always @(posedge MCLK) begin
		if (SYS_RST) begin
			pre_q <= {PRE_W{1'b0}};
			e1_q <= 2'h0;
			e2_q <= 2'h0;
			e3_q <= 2'h0;
			p1_q <= `RST_W32;
			p2_q <= `RST_W32;
			p3_q <= `RST_W32;
		end else begin
			pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
			// Pins are asynchronous, so two stages before any edge logic
			e1_q <= EXT_COUNT;
			e2_q <= e1_q;
			e3_q <= e2_q;
			p1_q <= CC_IN;
			p2_q <= p1_q;
			p3_q <= p2_q;
		end
	end

	genvar t, c;
	generate
		for (t = 0; t < 4; t = t + 1) begin : tm
			localparam [1:0] TI = t;
			localparam HAS_EXT = (t % 2 == 0);
			reg [5:0] ctl_q;
			reg [15:0] val_q, rel_q;
			reg upd_q, ovf_q;
			// Code 111 shifts past ten bits to zero; minus one masks 1023
			wire [9:0] pm = (`PRE_BASE << ctl_q[`TC_SEL]) - `PRE_ONE;
			wire pre_tick = (pre_q[9:0] & pm) == pm;
			wire ext_tick = HAS_EXT ? e_rise[t/2] : 1'b0;
			wire [1:0] src = ctl_q[`TC_SRC];
			wire tick = ctl_q[`TC_RUN] &&
				((src == `SRC_PRE && pre_tick) ||
				(src == `SRC_AUX && AUX_OVF) ||
				(src == `SRC_EXT && ext_tick));
			wire ws = wt && awa_q[5:4] == TI;
			always @(posedge MCLK) begin
				if (SYS_RST) begin
					ctl_q <= `RST_CTL;
					val_q <= `RST_W16;
					rel_q <= `RST_W16;
					upd_q <= 1'b0;
					ovf_q <= 1'b0;
				end else begin
					upd_q <= 1'b0;
					ovf_q <= 1'b0;
					if (ws && awa_q[3:2] == `TOFF_CTL && ws_q[0])
						ctl_q <= wd_q[5:0];
					if (ws && awa_q[3:2] == `TOFF_REL)
						rel_q <= mrg16(rel_q, wd_q[15:0], ws_q[1:0]);
					// Software write wins over a count in the same cycle
					if (ws && awa_q[3:2] == `TOFF_VAL) begin
						val_q <= mrg16(val_q, wd_q[15:0], ws_q[1:0]);
					end else if (tick) begin
						upd_q <= 1'b1;
						if (val_q == `TMR_TOP) begin
							val_q <= rel_q;
							ovf_q <= 1'b1;
						end else begin
							val_q <= val_q + 16'h0001;
						end
					end
				end
			end
			assign tval_f[16*t +: 16] = val_q;
			assign trel_f[16*t +: 16] = rel_q;
			assign tctl_f[6*t +: 6] = ctl_q;
			assign tupd[t] = upd_q;
			assign tovf[t] = ovf_q;
		end

		for (c = 0; c < 32; c = c + 1) begin : ch
			localparam [4:0] CI = c;
			localparam TB = 2 * (c / 16);
			// These four pins stay inputs whatever the mode
			localparam NO_DRV = (c >= 24) && (c <= 27);
			reg [15:0] v_q;
			reg [5:0] m_q;
			reg fired_q, out_q;
			wire [2:0] md = m_q[`CM_MODE];
			wire [1:0] eg = m_q[`CM_EDGE];
			wire ts = m_q[`CM_TSEL];
			wire [15:0] tv = ts ? tval_f[16*(TB+1) +: 16] :
				tval_f[16*TB +: 16];
			wire upd = ts ? tupd[TB+1] : tupd[TB];
			wire ovf = ts ? tovf[TB+1] : tovf[TB];
			wire cap = md == `MD_CAP &&
				((eg[0] && p_rise[c]) || (eg[1] && p_fall[c]));
			wire hit = upd && tv == v_q;
			// A match in the boundary cycle belongs to the new period
			wire once = !(fired_q && !ovf);
			wire m0 = md == `MD_C0 && hit;
			wire m2 = md == `MD_C2 && hit && once;
			wire m3 = md == `MD_C3 && hit && once;
			wire wsel = awa_q[6:2] == CI;
			assign evt[c] = cap || m0 || m2;
			assign tog[c] = hit && (md == `MD_C1 || md == `MD_DBL);
			assign dbl[c] = md == `MD_DBL;
			assign oem[c] = md == `MD_C1 || md == `MD_C3 || md == `MD_DBL;
			assign set3[c] = m3;
			assign clr3[c] = md == `MD_C3 && ovf;
			always @(posedge MCLK) begin
				if (SYS_RST) begin
					v_q <= `RST_W16;
					m_q <= `RST_CTL;
					fired_q <= 1'b0;
				end else begin
					if (cap)
						v_q <= tv;
					else if (wcv && wsel)
						v_q <= mrg16(v_q, wd_q[15:0], ws_q[1:0]);
					if (wcm && wsel && ws_q[0])
						m_q <= wd_q[5:0];
					// Set wins over a mode write or boundary in one cycle
					if (m2 || m3)
						fired_q <= 1'b1;
					else if (wcm && wsel)
						fired_q <= 1'b0;
					else if (ovf)
						fired_q <= 1'b0;
				end
			end
			assign cv_f[16*c +: 16] = v_q;
			assign cm_f[6*c +: 6] = m_q;

			// Pin side: lower eight of each array share with c+8
			wire ptog, pdbl;
			if ((c % 16) < 8) begin : pr
				assign ptog = tog[c] ^ (tog[c+8] && dbl[c+8]);
				assign pdbl = dbl[c+8];
			end else begin : np
				assign ptog = tog[c] && !dbl[c];
				assign pdbl = 1'b0;
			end
			always @(posedge MCLK) begin
				if (SYS_RST)
					out_q <= 1'b0;
				else if (set3[c])
					out_q <= 1'b1;
				else if (clr3[c])
					out_q <= 1'b0;
				else if (ptog)
					out_q <= ~out_q;
			end
			assign CC_OUT[c] = NO_DRV ? 1'b0 : out_q;
			// Upper partner in double mode gives its pin back as input
			assign CC_OE[c] = NO_DRV ? 1'b0 :
				((oem[c] && !(pdbl == 1'b0 && (c % 16) >= 8 &&
				dbl[c])) || pdbl);
		end
	endgenerate

	// Status and mask: a read of status clears it, a new event wins
	wire rd_st = rdo && S_AXI_ARADDR == `A_STATUS;
	always @(posedge MCLK) begin
		if (SYS_RST) begin
			st_q <= `RST_W32;
			mk_q <= `RST_W32;
		end else begin
			st_q <= (rd_st ? `RST_W32 : st_q) | evt;
			if (wmk)
				mk_q <= {mrg16(mk_q[31:16], wd_q[31:16], ws_q[3:2]),
					mrg16(mk_q[15:0], wd_q[15:0], ws_q[1:0])};
		end
	end
	// Level output: stays high until software reads status or masks
	assign IRQ = |(st_q & mk_q);

	// Read decode; unmapped addresses answer SLVERR with zero data
	wire [11:0] ra = S_AXI_ARADDR;
	always @* begin
		rd = `RST_W32;
		rok = 1'b1;
		if (ra[11:6] == `A_TMR_REGION) begin
			case (ra[3:2])
				`TOFF_CTL: rd = {26'h000_0000, tctl_f[6*ra[5:4] +: 6]};
				`TOFF_VAL: rd = {16'h0000, tval_f[16*ra[5:4] +: 16]};
				`TOFF_REL: rd = {16'h0000, trel_f[16*ra[5:4] +: 16]};
				default: rok = 1'b0;
			endcase
		end else if (ra[11:7] == `A_CHV_REGION) begin
			rd = {16'h0000, cv_f[16*ra[6:2] +: 16]};
		end else if (ra[11:7] == `A_CHM_REGION) begin
			rd = {26'h000_0000, cm_f[6*ra[6:2] +: 6]};
		end else if (ra == `A_STATUS) begin
			rd = st_q;
		end else if (ra == `A_MASK) begin
			rd = mk_q;
		end else begin
			rok = 1'b0;
		end
	end

	// Status takes writes with OKAY and ignores the data
	always @* begin
		wok = wcv || wcm || wmk || awa_q == `A_STATUS ||
			(wt && awa_q[3:2] != `TOFF_NONE);
	end

	always @(posedge MCLK) begin
		if (SYS_RST) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			awa_q <= 12'h000;
			wd_q <= `RST_W32;
			ws_q <= 4'h0;
			bresp_q <= `RESP_OKAY;
			rresp_q <= `RESP_OKAY;
			rdata_q <= `RST_W32;
		end else begin
			if (S_AXI_AWVALID && !aw_q && !b_q) begin
				aw_q <= 1'b1;
				awa_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_q && !b_q) begin
				w_q <= 1'b1;
				wd_q <= S_AXI_WDATA;
				ws_q <= S_AXI_WSTRB;
			end
			if (wdo) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				b_q <= 1'b1;
				bresp_q <= wok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (b_q && S_AXI_BREADY) begin
				b_q <= 1'b0;
			end
			if (rdo) begin
				r_q <= 1'b1;
				rdata_q <= rd;
				rresp_q <= rok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (r_q && S_AXI_RREADY) begin
				r_q <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// File: verification/cca_monitor.sv
// Checker for the capture/compare block: bus handshakes and pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cca_monitor (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Register bus
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] S_AXI_RRESP,
	// Pins and interrupt
	input wire logic [31:0] CC_OUT,
	input wire logic [31:0] CC_OE,
	input wire logic IRQ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	a_oe_quiet: assert property (CC_OE[27:24] == 4'h0)
		else $error("pins 24 to 27 enabled");
	a_out_quiet: assert property (CC_OUT[27:24] == 4'h0)
		else $error("pins 24 to 27 not low");
	a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		|=> S_AXI_RVALID) else $error("read not answered");
	a_rd_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RRESP)) else $error("read dropped");
	a_rd_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while busy");
	a_rd_done: assert property (S_AXI_RVALID && S_AXI_RREADY
		|=> !S_AXI_RVALID) else $error("read answer repeated");
	a_wr_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID) else $error("write answer dropped");
	a_wr_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
		else $error("write taken while busy");
	// Main scenarios
	cover property ($rose(IRQ));
	cover property ($rose(CC_OUT[6]));
	cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
endmodule
bind dual_capture_compare_array cca_monitor i_mon (.MCLK(MCLK),
	.SYS_RST(SYS_RST), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_RRESP(S_AXI_RRESP), .CC_OUT(CC_OUT), .CC_OE(CC_OE), .IRQ(IRQ));
`default_nettype wire

// File: verification/cca_pins.sv
// Pin world of the channels: loads on driven pins, sources elsewhere.
// Assumes the bench sets the source levels on clock edges.
`timescale 1ns/1ps
`default_nettype none
module cca_pins (
	// Channel drive
	input wire logic [31:0] CC_OUT,
	input wire logic [31:0] CC_OE,
	// External source levels
	input wire logic [31:0] src,
	// Levels seen at the pins
	output logic [31:0] CC_IN
);
	// A driven pin reads back its own level, so the source is overruled
	assign CC_IN = (CC_OE & CC_OUT) | (~CC_OE & src);
endmodule
`default_nettype wire

// File: verification/tb_dual_capture_compare_array.sv
// Bench for the capture/compare block: bus tasks, model and checks.
// Assumes the pin model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "cca_defs.vh"
module tb_dual_capture_compare_array;
	logic mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready, aux;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, src, cc_in, cc_out, cc_oe, v, a, b;
	logic [1:0] bresp, rresp, ext, resp;
	logic [14:0] mt = {`MD_DBL, `MD_C2, `MD_C0, `MD_C3, `MD_C1};
	integer failures = 0, n_compared = 0, seed = 32'h413a, cyc = 0;
	integer i, s, md, tm, pin, flag, done, ov, c0, k, cv, drv;
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;
	dual_capture_compare_array i_dut (.MCLK(mclk), .SYS_RST(sys_rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .CC_IN(cc_in), .CC_OUT(cc_out),
		.CC_OE(cc_oe), .EXT_COUNT(ext), .AUX_OVF(aux), .IRQ(irq));
	cca_pins i_pins (.CC_OUT(cc_out), .CC_OE(cc_oe), .src(src),
		.CC_IN(cc_in));
	task check(input logic [31:0] seen, input logic [31:0] exp, string n);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("mismatch %0s expected %h seen %h", n, exp, seen);
		end
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge mclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [11:0] ad, output logic [31:0] d);
		@(posedge mclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// One auxiliary overflow pulse, then time for the match to land
	task tick;
		@(posedge mclk);
		aux <= 1'b1;
		@(posedge mclk);
		aux <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task wrap_up;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		failures = failures + 1;
		wrap_up;
	end
	initial begin
		sys_rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, aux} = 6'h00;
		{awaddr, araddr, wdata, src, ext} = 90'h0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(12'h000, v);
		check(v, 32'h0000_0000, "ctl reset");
		v = $random(seed);
		wr(12'h028, v);
		check(resp, `RESP_OKAY, "write okay");
		rd(12'h028, a);
		check(a, v & 32'h0000_ffff, "reload");
		rd(12'h00c, a);
		check({resp, a[29:0]}, 32'h8000_0000, "unmapped");
		wr(12'h00c, v);
		check(resp, `RESP_SLVERR, "write unmapped");
		$display("register test done");
		wr(12'h000, 32'h0000_0020);
		wr(12'h20c, 32'h0000_0009);
		wr(12'h210, 32'h0000_0011);
		wr(`A_MASK, 32'h0000_0048);
		rd(12'h004, a);
		src <= 32'h0000_0018;
		repeat (8) @(posedge mclk);
		check(irq, 1'b1, "irq capture");
		rd(12'h10c, v);
		rd(12'h004, b);
		check(v >= a && v <= b, 1'b1, "capture");
		rd(`A_STATUS, v);
		check(v[4:3], 2'b01, "rise");
		src <= 32'h0000_0008;
		repeat (8) @(posedge mclk);
		check(irq, 1'b0, "masked");
		rd(`A_STATUS, v);
		check(v[4:3], 2'b10, "fall");
		$display("capture test done");
		wr(12'h020, 32'h0000_0030);
		rd(12'h024, a);
		repeat (3) begin
			ext <= 2'b11;
			repeat (6) @(posedge mclk);
			ext <= 2'b00;
			repeat (6) @(posedge mclk);
		end
		rd(12'h024, b);
		check(b[15:0], a[15:0] + 16'h0003, "ext count");
		// The prescaler runs free, so a window of cycles gives one of two counts
		for (s = 0; s < 8; s++) begin
			wr(12'h030, 32'h0000_0020 | s);
			rd(12'h034, a);
			c0 = cyc;
			repeat (32 << s) @(posedge mclk);
			rd(12'h034, b);
			md = ((b - a) & 32'h0000_ffff) * (8 << s);
			// The two reads sample three edges more than the wait spans
			tm = cyc - c0 + 3;
			check(md < tm + (8 << s) && md + (8 << s) > tm, 1'b1, "rate");
		end
		$display("timer test done");
		wr(12'h010, 32'h0000_0028);
		wr(12'h018, 32'h0000_fffc);
		pin = 0;
		for (i = 0; i < 5; i++) begin
			md = mt[3*i +: 3];
			drv = md == `MD_C1 || md == `MD_C3 || md == `MD_DBL;
			cv = 'hfffe;
			wr(12'h014, 32'h0000_fffc);
			wr(12'h118, 32'h0000_fffe);
			rd(`A_STATUS, v);
			// Upper partner of channel 6 joins only in double mode
			if (md == `MD_DBL) begin
				wr(12'h138, 32'h0000_fffd);
				wr(12'h238, 32'h0000_0026);
			end
			wr(12'h218, 32'h0000_0020 | md);
			tm = 'hfffc;
			flag = 0;
			done = 0;
			for (k = 0; k < 6; k++) begin
				tick;
				ov = tm == 'hffff;
				tm = ov ? 'hfffc : tm + 1;
				if (ov) done = 0;
				if (ov && md == `MD_C3) pin = 0;
				if (md == `MD_DBL && tm == 'hfffd) pin = !pin;
				if (tm == cv) begin
					if (md == `MD_C1 || md == `MD_DBL) pin = !pin;
					if (md == `MD_C3 && !done) pin = 1;
					if (md == `MD_C0 || (md == `MD_C2 && !done)) flag = 1;
					done = 1;
				end
				if (drv)
					check(cc_out[6], pin, "pin");
				check(irq, flag, "irq compare");
				// Move the value so a second match falls in this period
				if (k == 1) begin
					rd(`A_STATUS, v);
					check(v[6], flag, "first match");
					flag = 0;
					cv = 'hffff;
					wr(12'h118, 32'h0000_ffff);
				end
			end
			check(cc_oe[6], drv, "drive");
			check(cc_oe[14], 1'b0, "partner");
			rd(`A_STATUS, v);
			check(v[6], flag, "status");
		end
		wr(12'h018, 32'h0000_0000);
		wr(12'h014, 32'h0000_ffff);
		tick;
		rd(12'h014, v);
		check(v, 32'h0000_0000, "wrap");
		$display("compare test done");
		wrap_up;
	end
endmodule
`default_nettype wire
